/* File: rtl/ppctl_top.sv */
// Notes on behaviour
// - four mask bits enable edge detection on autofd, init, selectin, strobe
// - polarity bits per pin: zero selects falling edge, one selects rising
// - auto modes space driven signal changes by the pacing count in clocks
// - channel address in forward ecp transfer captured into read-only register
// - spp phase codes 00 idle, 01 data, 0F reset
// - 14 negotiate, 18 terminate, 24 reverse idle, 26 reverse data
// - 28 busy no data, 2C busy data, 2E host interrupt
// - ecp 30 fwd idle, 31 fwd data, 34 rev idle, 36 rev data
// - 38 recovery, 3C rev-to-fwd, 3E fwd-to-rev, 3F setup
// - from negotiation to reverse data or busy data go via reverse idle and host interrupt, never directly
// - pin select event in status bit 5, cleared when status read
`default_nettype none
module ppctl_top (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [31:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [31:0] wdata_in,
    output logic [31:0] rdata_out,
    output logic rvalid_out,
    input wire logic [3:0] pins_in,
    input wire logic auto_mode_in,
    input wire logic phase_req_in,
    input wire logic [7:0] phase_code_in,
    output logic phase_ack_out,
    output logic [7:0] phase_out,
    input wire logic sig_change_req_in,
    output logic sig_change_ack_out,
    input wire logic chan_addr_valid_in,
    input wire logic [7:0] chan_addr_in,
    output logic pin_select_event_out
);
    // ==========================================================
    // register decode
    wire logic sel_sts = addr_in == ppctl_pkg::PPCTL_ADDR_IRQ_STATUS;
    wire logic sel_en = addr_in == ppctl_pkg::PPCTL_ADDR_EDGE_ENABLE;
    wire logic sel_pol = addr_in == ppctl_pkg::PPCTL_ADDR_EDGE_POLARITY;
    wire logic sel_pace = addr_in == ppctl_pkg::PPCTL_ADDR_PACING;
    wire logic sel_chan = addr_in == ppctl_pkg::PPCTL_ADDR_CHAN_ADDR;
    wire logic sel_phase = addr_in == ppctl_pkg::PPCTL_ADDR_PHASE;

    logic [3:0] edge_en_q, edge_pol_q;
    logic [7:0] pace_q, pace_cnt_q, chan_addr_q, phase_q;
    logic psel_q, rvalid_q;
    logic [31:0] rdata_q;

    // ==========================================================
    // pin edge detection
    ppctl_pin_if pin_bus ();
    ppctl_pin_sync u_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .pins_in(pins_in),
        .pin_bus(pin_bus)
    );
    wire logic [3:0] sel_edge = (edge_pol_q & pin_bus.rise) | (~edge_pol_q & pin_bus.fall);
    wire logic evt_any = |(sel_edge & edge_en_q);
    wire logic sts_rd = rd_in & sel_sts;
    wire logic psel_d = evt_any | (psel_q & ~sts_rd);

    // ==========================================================
    // pacing and phase machine
    ppctl_pkg::ppctl_phase_e state_q, state_d, target_q;
    logic pending_q, pending_d;
    logic req_ok;
    ppctl_pkg::ppctl_phase_e req_state;
    always_comb begin
        req_state = ppctl_pkg::ppctl_decode(phase_code_in, req_ok);
    end
    wire logic pace_ready = ~auto_mode_in | (pace_cnt_q == ppctl_pkg::PPCTL_BYTE_RESET);
    wire logic req_rev = (req_state == ppctl_pkg::PH_NB_HB_DA) |
                         (req_state == ppctl_pkg::PH_NB_REV_DATA);
    wire logic detour_step = pending_q & pace_ready;
    wire logic take_req = phase_req_in & req_ok & pace_ready & ~pending_q;
    wire logic phase_move = detour_step | take_req;

    always_comb begin
        state_d = state_q;
        pending_d = pending_q;
        if (detour_step) begin
            case (state_q)
                ppctl_pkg::PH_NB_REV_IDLE: state_d = ppctl_pkg::PH_NB_HOST_INT;
                ppctl_pkg::PH_NB_HOST_INT: begin
                    state_d = target_q;
                    pending_d = 1'b0;
                end
                default: begin
                    state_d = target_q;
                    pending_d = 1'b0;
                end
            endcase
        end else if (take_req) begin
            if (state_q == ppctl_pkg::PH_NEG && req_rev) begin
                state_d = ppctl_pkg::PH_NB_REV_IDLE;
                pending_d = 1'b1;
            end else begin
                state_d = req_state;
            end
        end
    end

    assign sig_change_ack_out = sig_change_req_in & pace_ready & ~phase_move;
    wire logic change = phase_move | sig_change_ack_out;
    wire logic [7:0] pace_cnt_d = change ? pace_q :
        (pace_cnt_q == ppctl_pkg::PPCTL_BYTE_RESET ? pace_cnt_q : pace_cnt_q - 8'h01);
    wire logic fwd_ecp = (state_q == ppctl_pkg::PH_ECP_FWD_IDLE) |
                         (state_q == ppctl_pkg::PH_ECP_FWD_DATA);
    wire logic chan_cap = chan_addr_valid_in & fwd_ecp;

    // ==========================================================
    // read mux, reserved bits zero, unmapped zero
    wire logic [31:0] rd_mux =
        sel_sts ? {26'h0, psel_q, 5'h00} :
        sel_en ? {28'h0, edge_en_q} :
        sel_pol ? {28'h0, edge_pol_q} :
        sel_pace ? {24'h0, pace_q} :
        sel_chan ? {24'h0, chan_addr_q} :
        sel_phase ? {24'h0, phase_q} : ppctl_pkg::PPCTL_WORD_ZERO;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            edge_en_q <= ppctl_pkg::PPCTL_EDGE_RESET;
            edge_pol_q <= ppctl_pkg::PPCTL_EDGE_RESET;
            pace_q <= ppctl_pkg::PPCTL_BYTE_RESET;
        end else if (wr_in) begin
            if (sel_en) edge_en_q <= wdata_in[3:0];
            if (sel_pol) edge_pol_q <= wdata_in[3:0];
            if (sel_pace) pace_q <= wdata_in[7:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            psel_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= ppctl_pkg::PPCTL_WORD_ZERO;
            chan_addr_q <= ppctl_pkg::PPCTL_BYTE_RESET;
        end else begin
            psel_q <= psel_d;
            rvalid_q <= rd_in;
            rdata_q <= rd_in ? rd_mux : rdata_q;
            if (chan_cap) chan_addr_q <= chan_addr_in;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= ppctl_pkg::PH_SPP_IDLE;
            target_q <= ppctl_pkg::PH_SPP_IDLE;
            pending_q <= 1'b0;
            pace_cnt_q <= ppctl_pkg::PPCTL_BYTE_RESET;
            phase_q <= ppctl_pkg::PPCTL_C_SPP_IDLE;
        end else begin
            state_q <= state_d;
            pending_q <= pending_d;
            if (take_req) target_q <= req_state;
            pace_cnt_q <= pace_cnt_d;
            phase_q <= ppctl_pkg::ppctl_code(state_d);
        end
    end

    assign rdata_out = rdata_q;
    assign rvalid_out = rvalid_q;
    assign phase_ack_out = take_req;
    assign phase_out = phase_q;
    assign pin_select_event_out = psel_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    logic [8:0] since_q;
    logic [7:0] last_pace_q;
    logic seen_q;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            since_q <= 9'h000;
            last_pace_q <= 8'h00;
            seen_q <= 1'b0;
        end else begin
            since_q <= change ? 9'h000 : (since_q == 9'h1FF ? since_q : since_q + 9'h001);
            if (change) last_pace_q <= pace_q;
            if (change) seen_q <= 1'b1;
        end
    end

    property p_en_wr;
        wr_in && sel_en |=> edge_en_q == $past(wdata_in[3:0]);
    endproperty
    a_en_wr: assert property (p_en_wr) else $error("enable write lost");
    property p_pol_wr;
        wr_in && sel_pol |=> edge_pol_q == $past(wdata_in[3:0]);
    endproperty
    a_pol_wr: assert property (p_pol_wr) else $error("polarity write lost");
    property p_evt_set;
        (|(edge_en_q & ~edge_pol_q & pin_bus.fall)) |=> psel_q;
    endproperty
    a_evt_set: assert property (p_evt_set) else $error("falling edge event missed");
    property p_evt_cause;
        $rose(psel_q) |-> $past(|(edge_en_q & ((edge_pol_q & pin_bus.rise) |
                                              (~edge_pol_q & pin_bus.fall))));
    endproperty
    a_evt_cause: assert property (p_evt_cause) else $error("event without enabled edge");
    property p_rd_clear;
        sts_rd && !evt_any |=> !psel_q ##1
            rdata_q[ppctl_pkg::PPCTL_STS_PIN_SELECT_BIT] == $past(psel_q, 2);
    endproperty
    a_rd_clear: assert property (p_rd_clear) else $error("status not cleared on read");
    property p_pace;
        change && auto_mode_in && seen_q |-> since_q >= {1'b0, last_pace_q};
    endproperty
    a_pace: assert property (p_pace) else $error("signal change too soon");
    property p_chan;
        chan_cap |=> chan_addr_q == $past(chan_addr_in) ##0 phase_q[7:4] == 4'h3;
    endproperty
    a_chan: assert property (p_chan) else $error("channel address not captured");
    property p_chan_hold;
        !chan_cap |=> $stable(chan_addr_q);
    endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel address changed");
    property p_code;
        phase_q == ppctl_pkg::ppctl_code(state_q);
    endproperty
    a_code: assert property (p_code) else $error("phase code mismatch");
    property p_detour;
        state_q == ppctl_pkg::PH_NEG |=> state_q != ppctl_pkg::PH_NB_HB_DA &&
                                         state_q != ppctl_pkg::PH_NB_REV_DATA;
    endproperty
    a_detour: assert property (p_detour) else $error("direct entry to reverse data");

    c_evt: cover property (evt_any ##1 psel_q ##[1:20] sts_rd);
    c_detour: cover property (state_q == ppctl_pkg::PH_NB_HOST_INT ##[1:300] !pending_q);
    c_chan: cover property (chan_cap);
    c_pace: cover property (sig_change_ack_out && auto_mode_in && pace_q != 8'h00);
endmodule : ppctl_top
`default_nettype wire

/* File: rtl/ppctl_pkg.sv */
`default_nettype none
package ppctl_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [31:0] PPCTL_ADDR_IRQ_STATUS = 32'h9040_012C;
    localparam logic [31:0] PPCTL_ADDR_EDGE_ENABLE = 32'h9040_0134;
    localparam logic [31:0] PPCTL_ADDR_EDGE_POLARITY = 32'h9040_0138;
    localparam logic [31:0] PPCTL_ADDR_PACING = 32'h9040_0168;
    localparam logic [31:0] PPCTL_ADDR_CHAN_ADDR = 32'h9040_0174;
    localparam logic [31:0] PPCTL_ADDR_PHASE = 32'h9040_0178;

    // ==========================================================
    // field layout and reset values
    localparam int PPCTL_NUM_PINS = 4;
    localparam int PPCTL_PIN_STROBE = 0;
    localparam int PPCTL_PIN_SELECTIN = 1;
    localparam int PPCTL_PIN_INIT = 2;
    localparam int PPCTL_PIN_AUTOFD = 3;
    localparam int PPCTL_STS_PIN_SELECT_BIT = 5;
    localparam logic [3:0] PPCTL_EDGE_RESET = 4'h0;
    localparam logic [7:0] PPCTL_BYTE_RESET = 8'h00;
    localparam logic [31:0] PPCTL_WORD_ZERO = 32'h0000_0000;

    // ==========================================================
    // timing: minimum setup pulse width software must cover
    localparam int PPCTL_CLK_PERIOD_NS = 8;
    localparam int PPCTL_TP_NS = 500;
    localparam int PPCTL_TP_CYCLES = (PPCTL_TP_NS + PPCTL_CLK_PERIOD_NS - 1) / PPCTL_CLK_PERIOD_NS;

    // ==========================================================
    // protocol phase codes
    localparam logic [7:0] PPCTL_C_SPP_IDLE = 8'h00;
    localparam logic [7:0] PPCTL_C_SPP_DATA = 8'h01;
    localparam logic [7:0] PPCTL_C_SPP_RESET = 8'h0F;
    localparam logic [7:0] PPCTL_C_NEG = 8'h14;
    localparam logic [7:0] PPCTL_C_TERM = 8'h18;
    localparam logic [7:0] PPCTL_C_NB_REV_IDLE = 8'h24;
    localparam logic [7:0] PPCTL_C_NB_REV_DATA = 8'h26;
    localparam logic [7:0] PPCTL_C_NB_HB_NDA = 8'h28;
    localparam logic [7:0] PPCTL_C_NB_HB_DA = 8'h2C;
    localparam logic [7:0] PPCTL_C_NB_HOST_INT = 8'h2E;
    localparam logic [7:0] PPCTL_C_ECP_FWD_IDLE = 8'h30;
    localparam logic [7:0] PPCTL_C_ECP_FWD_DATA = 8'h31;
    localparam logic [7:0] PPCTL_C_ECP_REV_IDLE = 8'h34;
    localparam logic [7:0] PPCTL_C_ECP_REV_DATA = 8'h36;
    localparam logic [7:0] PPCTL_C_ECP_RECOV = 8'h38;
    localparam logic [7:0] PPCTL_C_ECP_R2F = 8'h3C;
    localparam logic [7:0] PPCTL_C_ECP_F2R = 8'h3E;
    localparam logic [7:0] PPCTL_C_ECP_SETUP = 8'h3F;

    typedef enum logic [4:0] {
        PH_SPP_IDLE, PH_SPP_DATA, PH_SPP_RESET, PH_NEG, PH_TERM,
        PH_NB_REV_IDLE, PH_NB_REV_DATA, PH_NB_HB_NDA, PH_NB_HB_DA, PH_NB_HOST_INT,
        PH_ECP_FWD_IDLE, PH_ECP_FWD_DATA, PH_ECP_REV_IDLE, PH_ECP_REV_DATA,
        PH_ECP_RECOV, PH_ECP_R2F, PH_ECP_F2R, PH_ECP_SETUP
    } ppctl_phase_e;

    function automatic logic [7:0] ppctl_code(input ppctl_phase_e s);
        case (s)
            PH_SPP_IDLE: ppctl_code = PPCTL_C_SPP_IDLE;
            PH_SPP_DATA: ppctl_code = PPCTL_C_SPP_DATA;
            PH_SPP_RESET: ppctl_code = PPCTL_C_SPP_RESET;
            PH_NEG: ppctl_code = PPCTL_C_NEG;
            PH_TERM: ppctl_code = PPCTL_C_TERM;
            PH_NB_REV_IDLE: ppctl_code = PPCTL_C_NB_REV_IDLE;
            PH_NB_REV_DATA: ppctl_code = PPCTL_C_NB_REV_DATA;
            PH_NB_HB_NDA: ppctl_code = PPCTL_C_NB_HB_NDA;
            PH_NB_HB_DA: ppctl_code = PPCTL_C_NB_HB_DA;
            PH_NB_HOST_INT: ppctl_code = PPCTL_C_NB_HOST_INT;
            PH_ECP_FWD_IDLE: ppctl_code = PPCTL_C_ECP_FWD_IDLE;
            PH_ECP_FWD_DATA: ppctl_code = PPCTL_C_ECP_FWD_DATA;
            PH_ECP_REV_IDLE: ppctl_code = PPCTL_C_ECP_REV_IDLE;
            PH_ECP_REV_DATA: ppctl_code = PPCTL_C_ECP_REV_DATA;
            PH_ECP_RECOV: ppctl_code = PPCTL_C_ECP_RECOV;
            PH_ECP_R2F: ppctl_code = PPCTL_C_ECP_R2F;
            PH_ECP_F2R: ppctl_code = PPCTL_C_ECP_F2R;
            PH_ECP_SETUP: ppctl_code = PPCTL_C_ECP_SETUP;
            default: ppctl_code = PPCTL_C_SPP_IDLE;
        endcase
    endfunction : ppctl_code

    // decode a requested code; valid_o low for unknown codes
    function automatic ppctl_phase_e ppctl_decode(input logic [7:0] c, output logic valid_o);
        ppctl_phase_e r;
        r = PH_SPP_IDLE;
        valid_o = 1'b0;
        for (int i = 0; i <= int'(PH_ECP_SETUP); i++) begin
            if (ppctl_code(ppctl_phase_e'(i)) == c) begin
                r = ppctl_phase_e'(i);
                valid_o = 1'b1;
            end
        end
        return r;
    endfunction : ppctl_decode
endpackage : ppctl_pkg
`default_nettype wire

/* File: rtl/ppctl_pin_if.sv */
`default_nettype none
interface ppctl_pin_if;
    logic [3:0] level;
    logic [3:0] rise;
    logic [3:0] fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : ppctl_pin_if
`default_nettype wire

/* File: rtl/ppctl_pin_sync.sv */
`default_nettype none
module ppctl_pin_sync (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [3:0] pins_in,
    ppctl_pin_if.src pin_bus
);
    // ==========================================================
    // three-stage synchroniser with agreement filter
    logic [3:0] s1_q, s2_q, s3_q, stable_q;
    wire logic [3:0] agree = ~(s2_q ^ s3_q);
    wire logic [3:0] stable_d = (agree & s3_q) | (~agree & stable_q);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s1_q <= ppctl_pkg::PPCTL_EDGE_RESET;
            s2_q <= ppctl_pkg::PPCTL_EDGE_RESET;
            s3_q <= ppctl_pkg::PPCTL_EDGE_RESET;
            stable_q <= ppctl_pkg::PPCTL_EDGE_RESET;
        end else begin
            s1_q <= pins_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= stable_d;
        end
    end

    // compare new agreed sample with previous one
    assign pin_bus.level = stable_q;
    assign pin_bus.rise = stable_d & ~stable_q;
    assign pin_bus.fall = ~stable_d & stable_q;

    // ==========================================================
    // checks
    property p_edge_agreed;
        @(posedge clk_in) disable iff (rst_in)
        (pin_bus.rise | pin_bus.fall) != 4'h0 |-> ((pin_bus.rise | pin_bus.fall) & ~agree) == 4'h0;
    endproperty
    a_edge_agreed: assert property (p_edge_agreed) else $error("edge without agreement");
endmodule : ppctl_pin_sync
`default_nettype wire

/* File: tb/ppctl_host_model.sv */
`default_nettype none
module ppctl_host_model (
    input wire logic clk_in,
    output logic [3:0] pins_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // host pin drivers, active-low lines idle high
    initial begin
        pins_out = 4'hF;
    end
    // moves one pin off the sampling edge
    task automatic set_pin(input int idx, input logic lvl);
        @(negedge clk_in);
        pins_out[idx] = lvl;
    endtask : set_pin
endmodule : ppctl_host_model
`default_nettype wire

/* File: tb/ppctl_top_tb.sv */
`default_nettype none
module ppctl_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_in, rst_in, wr_in, rd_in, rvalid_out, auto_mode_in, phase_req_in, phase_ack_out;
    logic sig_change_req_in, sig_change_ack_out, chan_addr_valid_in, pin_select_event_out;
    logic [31:0] addr_in, wdata_in, rdata_out;
    logic [7:0] phase_code_in, phase_out, chan_addr_in;
    logic [3:0] pins;
    int n_errors = 0;
    int samples_checked = 0;
    ppctl_top i_ppctl_top (.clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wr_in(wr_in),
        .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out),
        .pins_in(pins), .auto_mode_in(auto_mode_in), .phase_req_in(phase_req_in),
        .phase_code_in(phase_code_in), .phase_ack_out(phase_ack_out), .phase_out(phase_out),
        .sig_change_req_in(sig_change_req_in), .sig_change_ack_out(sig_change_ack_out),
        .chan_addr_valid_in(chan_addr_valid_in), .chan_addr_in(chan_addr_in),
        .pin_select_event_out(pin_select_event_out));
    ppctl_host_model i_ppctl_host_model (.clk_in(clk_in), .pins_out(pins));
    initial begin
        clk_in = 1'b0;
        forever #4 clk_in = ~clk_in;
    end
    // ==========================================================
    // reporting
    task automatic finish_test;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // ==========================================================
    // register port
    task automatic reg_wr(input logic [31:0] a, input logic [31:0] d);
        @(negedge clk_in);
        addr_in = a;
        wdata_in = d;
        wr_in = 1'b1;
        @(negedge clk_in);
        wr_in = 1'b0;
    endtask : reg_wr
    task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
        @(negedge clk_in);
        addr_in = a;
        rd_in = 1'b1;
        @(negedge clk_in);
        rd_in = 1'b0;
        chk("rvalid", 32'h1, {31'h0, rvalid_out});
        chk(what, exp, rdata_out);
    endtask : rd_chk
    task automatic phase_move(input logic [7:0] code);
        int k;
        @(negedge clk_in);
        phase_code_in = code;
        phase_req_in = 1'b1;
        for (k = 0; k < 200; k++) begin
            #1;
            if (phase_ack_out === 1'b1) break;
            @(negedge clk_in);
        end
        if (k == 200) begin
            n_errors++;
            $display("wrong value phase_ack expected 1 seen timeout");
            finish_test();
        end
        @(negedge clk_in);
        phase_req_in = 1'b0;
    endtask : phase_move
    // ==========================================================
    // scenarios
    task automatic t_reset;
        rd_chk("enable", ppctl_pkg::PPCTL_ADDR_EDGE_ENABLE, 32'h0);
        rd_chk("polarity", ppctl_pkg::PPCTL_ADDR_EDGE_POLARITY, 32'h0);
        rd_chk("pacing", ppctl_pkg::PPCTL_ADDR_PACING, 32'h0);
        rd_chk("chan", ppctl_pkg::PPCTL_ADDR_CHAN_ADDR, 32'h0);
        rd_chk("phase", ppctl_pkg::PPCTL_ADDR_PHASE, 32'h0);
        rd_chk("status", ppctl_pkg::PPCTL_ADDR_IRQ_STATUS, 32'h0);
        rd_chk("unmapped", 32'h9040_0100, 32'h0);
    endtask : t_reset
    task automatic t_regs;
        reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_ENABLE, 32'hFFFF_FFFF);
        rd_chk("enable", ppctl_pkg::PPCTL_ADDR_EDGE_ENABLE, 32'h0000_000F);
        reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_POLARITY, 32'hFFFF_FFFA);
        rd_chk("polarity", ppctl_pkg::PPCTL_ADDR_EDGE_POLARITY, 32'h0000_000A);
        reg_wr(ppctl_pkg::PPCTL_ADDR_PACING, 32'hFFFF_FF5A);
        rd_chk("pacing", ppctl_pkg::PPCTL_ADDR_PACING, 32'h0000_005A);
        reg_wr(ppctl_pkg::PPCTL_ADDR_CHAN_ADDR, 32'hFF);
        rd_chk("chan ro", ppctl_pkg::PPCTL_ADDR_CHAN_ADDR, 32'h0);
        reg_wr(ppctl_pkg::PPCTL_ADDR_PHASE, 32'h3F);
        rd_chk("phase ro", ppctl_pkg::PPCTL_ADDR_PHASE, 32'h0);
        reg_wr(32'h9040_0100, 32'h55);
        rd_chk("unmapped", 32'h9040_0100, 32'h0);
        reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_ENABLE, 32'h0);
        reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_POLARITY, 32'h0);
    endtask : t_regs
    // drives one pin, watches for the event, then reads status twice
    task automatic edge_case(input int pin, input logic lvl, input logic exp);
        logic seen;
        seen = 1'b0;
        i_ppctl_host_model.set_pin(pin, lvl);
        repeat (10) begin
            @(negedge clk_in);
            if (pin_select_event_out === 1'b1) seen = 1'b1;
        end
        chk("pin_select_event", {31'h0, exp}, {31'h0, seen});
        rd_chk("status", ppctl_pkg::PPCTL_ADDR_IRQ_STATUS, {26'h0, exp, 5'h0});
        rd_chk("status cleared", ppctl_pkg::PPCTL_ADDR_IRQ_STATUS, 32'h0);
    endtask : edge_case
    task automatic t_pins;
        for (int i = 0; i < 4; i++) begin
            reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_ENABLE, 32'h1 << i);
            edge_case(i, 1'b0, 1'b1);
            edge_case(i, 1'b1, 1'b0);
            reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_POLARITY, 32'h1 << i);
            edge_case(i, 1'b0, 1'b0);
            edge_case(i, 1'b1, 1'b1);
            reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_ENABLE, 32'h1 << ((i + 1) % 4));
            edge_case(i, 1'b0, 1'b0);
            edge_case(i, 1'b1, 1'b0);
            reg_wr(ppctl_pkg::PPCTL_ADDR_EDGE_POLARITY, 32'h0);
        end
    endtask : t_pins
    task automatic t_phase;
        logic [7:0] codes [18];
        codes = '{8'h00, 8'h01, 8'h0F, 8'h14, 8'h18, 8'h24, 8'h26, 8'h28, 8'h2C,
            8'h2E, 8'h30, 8'h31, 8'h34, 8'h36, 8'h38, 8'h3C, 8'h3E, 8'h3F};
        foreach (codes[i]) begin
            phase_move(codes[i]);
            chk("phase_out", {24'h0, codes[i]}, {24'h0, phase_out});
            rd_chk("phase reg", ppctl_pkg::PPCTL_ADDR_PHASE, {24'h0, codes[i]});
        end
        // unknown code is refused and the phase holds
        @(negedge clk_in);
        phase_code_in = 8'h55;
        phase_req_in = 1'b1;
        #1;
        chk("phase_ack refused", 32'h0, {31'h0, phase_ack_out});
        @(negedge clk_in);
        phase_req_in = 1'b0;
        chk("phase held", 32'h3F, {24'h0, phase_out});
    endtask : t_phase
    task automatic t_detour;
        logic [7:0] seen [$];
        logic [7:0] prev;
        phase_move(8'h14);
        phase_move(8'h2C);
        prev = 8'h14;
        repeat (300) begin
            if (phase_out !== prev) seen.push_back(phase_out);
            prev = phase_out;
            @(negedge clk_in);
        end
        chk("detour steps", 32'h3, seen.size());
        if (seen.size() == 3) begin
            chk("detour 1", 32'h24, {24'h0, seen[0]});
            chk("detour 2", 32'h2E, {24'h0, seen[1]});
            chk("detour 3", 32'h2C, {24'h0, seen[2]});
        end
    endtask : t_detour
    task automatic t_pacing;
        int last, n_acks;
        logic gap_ok;
        last = -1;
        n_acks = 0;
        // 63 clocks of 8 ns cover the 500 ns setup width
        reg_wr(ppctl_pkg::PPCTL_ADDR_PACING, 32'd63);
        auto_mode_in = 1'b1;
        sig_change_req_in = 1'b1;
        for (int c = 0; c < 300; c++) begin
            @(negedge clk_in);
            #1;
            if (sig_change_ack_out === 1'b1) begin
                gap_ok = (c - last >= 63) && (c - last <= 65);
                if (last >= 0) chk("pacing gap ok", 32'h1, {31'h0, gap_ok});
                last = c;
                n_acks++;
            end
        end
        chk("pacing ack count", 32'h1, {31'h0, n_acks >= 3});
        @(negedge clk_in);
        sig_change_req_in = 1'b0;
        auto_mode_in = 1'b0;
    endtask : t_pacing
    task automatic pulse_chan(input logic [7:0] a);
        @(negedge clk_in);
        chan_addr_in = a;
        chan_addr_valid_in = 1'b1;
        @(negedge clk_in);
        chan_addr_valid_in = 1'b0;
    endtask : pulse_chan
    task automatic t_chan;
        phase_move(8'h31);
        pulse_chan(8'hA5);
        rd_chk("chan fwd data", ppctl_pkg::PPCTL_ADDR_CHAN_ADDR, 32'hA5);
        phase_move(8'h00);
        pulse_chan(8'h5A);
        rd_chk("chan not ecp", ppctl_pkg::PPCTL_ADDR_CHAN_ADDR, 32'hA5);
        phase_move(8'h30);
        pulse_chan(8'h3C);
        rd_chk("chan fwd idle", ppctl_pkg::PPCTL_ADDR_CHAN_ADDR, 32'h3C);
    endtask : t_chan
    // ==========================================================
    // main sequence
    initial begin
        rst_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 32'h0;
        wdata_in = 32'h0;
        auto_mode_in = 1'b0;
        phase_req_in = 1'b0;
        phase_code_in = 8'h00;
        sig_change_req_in = 1'b0;
        chan_addr_valid_in = 1'b0;
        chan_addr_in = 8'h00;
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (6) @(negedge clk_in);
        t_reset();
        t_regs();
        t_pins();
        t_phase();
        t_detour();
        t_pacing();
        t_chan();
        finish_test();
    end
endmodule : ppctl_top_tb
`default_nettype wire
